// [core/dsc_port_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module dsc_port_ctrl
    import dsc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Serial port pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  sdio_in,
    output logic      [3:0]  sdio_out,
    output logic      [3:0]  sdio_oe,
    input  wire logic        io_update,
    // Shared pin functions
    output logic      [1:0]  amplitude_ramp_control,
    // Active register view
    input  wire logic [1:0]  act_ch,
    input  wire logic [4:0]  act_addr,
    output logic      [31:0] act_data,
    // Status
    output logic      [3:0]  chan_enable,
    output logic      [1:0]  ser_mode
);
    localparam int NSLOT = NUM_CH * NUM_REGS;
    localparam int FW    = 15;

    // ============================================================
    // Helper functions
    function automatic logic [2:0] reg_bytes(input logic [4:0] a);
        if (a == CHSEL_OFFSET) begin
            return CHSEL_BYTES;
        end else if (a == FCFG1_OFFSET) begin
            return FCFG1_BYTES;
        end
        return DEF_BYTES;
    endfunction

    function automatic logic is_shared(input logic [4:0] a);
        return (a >= SHARED_LO) && (a <= SHARED_HI);
    endfunction

    function automatic logic [6:0] slot(input logic [1:0] ch, input logic [4:0] a);
        int s;
        s = is_shared(a) ? int'(ch) * NUM_REGS + int'(a) : int'(a);
        return 7'(s);
    endfunction

    function automatic logic [7:0] ins_bits(input logic [7:0] cur, input logic [3:0] pins,
                                            input logic [2:0] pos, input logic [2:0] w);
        logic [7:0] b;
        int         lo;
        b  = cur;
        lo = int'(pos) * int'(w);
        for (int i = 0; i < 8; i++) begin
            if (i >= lo && i < lo + int'(w)) begin
                b[i] = pins[i - lo];
            end
        end
        return b;
    endfunction

    function automatic logic [3:0] get_bits(input logic [7:0] byt, input logic [2:0] pos,
                                            input logic [2:0] w);
        logic [3:0] o;
        int         lo;
        o  = 4'h0;
        lo = int'(pos) * int'(w);
        for (int k = 0; k < 4; k++) begin
            if (k < int'(w)) begin
                o[k] = byt[(lo + k) % 8];
            end
        end
        return o;
    endfunction

    // ============================================================
    // Pin synchronisation and edge detection
    logic [6:0] sy;

    dsc_sync #(.W(7), .RST(7'h02)) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    ({io_update, sdio_in, cs_n, sclk}),
        .q    (sy)
    );

    wire       sclk_s   = sy[0];
    wire       cs_n_s   = sy[1];
    wire [3:0] sdio_s   = sy[5:2];
    wire       upd_s    = sy[6];

    logic       sclk_q_r;
    logic       upd_q_r;
    dsc_state_e st_r;
    logic [2:0] step_r;
    logic [1:0] bcnt_r;
    logic [7:0] asm_r;
    logic [4:0] addr_r;
    logic [31:0] rd_word_r;
    logic [3:0] chan_r;
    logic [7:0] chsel_buf_r;
    logic [7:0] chsel_act_r;
    logic [3:0] sdio_out_r;
    logic [3:0] sdio_oe_r;
    logic [1:0] ramp_r;
    logic [31:0] act_data_r;
    logic        push_pend_r;
    logic [FW-1:0] push_word_r;
    logic [31:0] buf_r [0:NSLOT-1];
    logic [31:0] act_r [0:NSLOT-1];

    wire active    = ~cs_n_s;
    wire sclk_rise = active & sclk_s & ~sclk_q_r;
    wire sclk_fall = active & ~sclk_s & sclk_q_r;
    wire upd_rise  = upd_s & ~upd_q_r;

    // ============================================================
    // Mode decode
    wire [1:0] mode      = chsel_act_r[CHSEL_MODE_LSB +: 2];
    wire       lsb_first = chsel_act_r[CHSEL_ORDER_BIT];
    wire [2:0] lane_w    = (mode == MODE_QUAD) ? 3'h4 :
                           (mode == MODE_DUAL) ? 3'h2 : 3'h1;
    wire [2:0] last_step = (mode == MODE_QUAD) ? 3'h1 :
                           (mode == MODE_DUAL) ? 3'h3 : 3'h7;
    wire       resync    = (mode != MODE_QUAD) & sdio_s[3];
    wire [3:0] oe_mask   = (mode == MODE_QUAD)    ? 4'hf :
                           (mode == MODE_DUAL)    ? 4'h3 :
                           (mode == MODE_SINGLE3) ? 4'h4 : 4'h1;
    wire [2:0] cpos      = lsb_first ? step_r : 3'(last_step - step_r);

    // ============================================================
    // Sequencing
    wire [2:0] nbytes    = reg_bytes(addr_r);
    wire       step_last = (step_r == last_step);
    wire       byte_last = (3'(bcnt_r) == 3'(nbytes - 3'h1));
    wire [1:0] byte_idx  = lsb_first ? bcnt_r : 2'(nbytes - 3'h1 - 3'(bcnt_r));
    wire [7:0] asm_nxt   = ins_bits(asm_r, sdio_s, cpos, lane_w);
    wire       ins_done  = sclk_rise & (st_r == ST_INSTR) & step_last;
    wire       wbyte_done = sclk_rise & (st_r == ST_WDATA) & step_last;
    wire       rd_end    = sclk_rise & (st_r == ST_RDATA) & step_last & byte_last;
    wire       wr_end    = wbyte_done & byte_last;
    wire [4:0] ins_addr  = asm_nxt[INS_ADDR_MSB:0];
    wire [7:0] rd_byte   = rd_word_r[8 * byte_idx +: 8];
    wire [3:0] rd_bits   = get_bits(rd_byte, cpos, lane_w);
    wire [3:0] rd_pins   = (mode == MODE_SINGLE3) ? {1'b0, rd_bits[0], 2'b00} : rd_bits;

    // Read source: active copy of the lowest enabled channel (channel 3 if none); channel select reads the live enables
    wire [1:0] rd_ch     = chan_r[0] ? 2'h0 : chan_r[1] ? 2'h1 : chan_r[2] ? 2'h2 : 2'h3;
    wire [31:0] rd_sel   = (ins_addr == CHSEL_OFFSET) ? {24'h0, chan_r, chsel_act_r[3:0]} :
                           (ins_addr > SHARED_HI)   ? 32'h0 :
                           act_r[slot(rd_ch, ins_addr)];

    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_q_r <= 1'b0;
            upd_q_r  <= 1'b0;
        end else begin
            sclk_q_r <= sclk_s;
            upd_q_r  <= upd_s;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r   <= ST_INSTR;
            step_r <= 3'h0;
            bcnt_r <= 2'h0;
            asm_r  <= 8'h00;
            addr_r <= 5'h00;
        end else if (resync) begin
            st_r   <= ST_INSTR;
            step_r <= 3'h0;
            bcnt_r <= 2'h0;
            asm_r  <= 8'h00;
        end else if (sclk_rise) begin
            asm_r  <= asm_nxt;
            step_r <= step_last ? 3'h0 : 3'(step_r + 3'h1);
            unique case (st_r)
                ST_INSTR: begin
                    if (step_last) begin
                        addr_r <= ins_addr;
                        bcnt_r <= 2'h0;
                        st_r   <= asm_nxt[INS_RW_BIT] ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_WDATA, ST_RDATA: begin
                    if (step_last) begin
                        bcnt_r <= 2'(bcnt_r + 2'h1);
                        if (byte_last) begin
                            st_r <= ST_INSTR;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_word_r <= 32'h0;
        end else if (ins_done) begin
            rd_word_r <= rd_sel;
        end
    end

    // ============================================================
    // Read data drive
    always_ff @(posedge clk) begin
        if (srst) begin
            sdio_out_r <= 4'h0;
            sdio_oe_r  <= 4'h0;
        end else if (~active | resync | rd_end) begin
            sdio_oe_r  <= 4'h0;
        end else if (sclk_fall & (st_r == ST_RDATA)) begin
            sdio_out_r <= rd_pins;
            sdio_oe_r  <= oe_mask;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_r <= 2'h0;
        end else begin
            ramp_r[0] <= (mode == MODE_SINGLE2 || mode == MODE_SINGLE3) & sdio_s[1];
            ramp_r[1] <= (mode == MODE_SINGLE2 || mode == MODE_DUAL) & sdio_s[2];
        end
    end

    // ============================================================
    // Completed bytes into the FIFO
    logic          f_ready;
    logic          f_out_valid;
    logic [FW-1:0] f_out_data;
    wire           f_pop = f_out_valid & ~upd_rise;

    always_ff @(posedge clk) begin
        if (srst) begin
            push_pend_r <= 1'b0;
            push_word_r <= '0;
        end else begin
            push_pend_r <= wbyte_done | (push_pend_r & ~f_ready);
            if (wbyte_done) begin
                push_word_r <= {addr_r, byte_idx, asm_nxt};
            end
        end
    end

    dsc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (push_pend_r),
        .in_ready  (f_ready),
        .in_data   (push_word_r),
        .out_valid (f_out_valid),
        .out_ready (~upd_rise),
        .out_data  (f_out_data)
    );

    wire [4:0] d_addr = f_out_data[14:10];
    wire [1:0] d_idx  = f_out_data[9:8];
    wire [7:0] d_byte = f_out_data[7:0];
    wire       d_chsel = f_pop & (d_addr == CHSEL_OFFSET);

    // ============================================================
    // Channel select register
    always_ff @(posedge clk) begin
        if (srst) begin
            chan_r      <= CHSEL_RESET[CHSEL_CHAN_LSB +: 4];
            chsel_buf_r <= CHSEL_RESET;
            chsel_act_r <= CHSEL_RESET;
        end else begin
            if (d_chsel) begin
                chan_r      <= d_byte[CHSEL_CHAN_LSB +: 4];
                chsel_buf_r <= d_byte;
            end
            if (upd_rise) begin
                chsel_act_r <= chsel_buf_r;
            end
        end
    end

    // ============================================================
    // Buffer and active register copies
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NSLOT; i++) begin
                buf_r[i] <= 32'h0;
            end
        end else if (f_pop & (d_addr != CHSEL_OFFSET) & (d_addr <= SHARED_HI)) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (chan_r[c] | ~is_shared(d_addr)) begin
                    buf_r[slot(2'(c), d_addr)][8 * d_idx +: 8] <= d_byte;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NSLOT; i++) begin
                act_r[i] <= 32'h0;
            end
        end else if (upd_rise) begin
            for (int i = 0; i < NSLOT; i++) begin
                act_r[i] <= buf_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            act_data_r <= 32'h0;
        end else begin
            act_data_r <= (act_addr > SHARED_HI) ? 32'h0 : act_r[slot(act_ch, act_addr)];
        end
    end

    assign sdio_out               = sdio_out_r;
    assign sdio_oe                = sdio_oe_r;
    assign amplitude_ramp_control = ramp_r;
    assign act_data               = act_data_r;
    assign chan_enable            = chan_r;
    assign ser_mode               = chsel_act_r[CHSEL_MODE_LSB +: 2];

    // ============================================================
    // Checks
    a_cs_high_release:  assert property (@(posedge clk) disable iff (srst)
        cs_n_s |=> sdio_oe_r == 4'h0) else $error("data pins driven with chip select high");
    a_write_dir_start:  assert property (@(posedge clk) disable iff (srst)
        ins_done & ~resync & ~asm_nxt[7] |=> st_r == ST_WDATA) else $error("write phase not entered");
    a_read_dir_start:   assert property (@(posedge clk) disable iff (srst)
        ins_done & ~resync & asm_nxt[7] |=> st_r == ST_RDATA ##0 rd_word_r == $past(rd_sel))
        else $error("read phase or read word wrong");
    a_resync_abort:     assert property (@(posedge clk) disable iff (srst)
        resync |=> st_r == ST_INSTR && step_r == 3'h0 && sdio_oe_r == 4'h0) else $error("resync did not abort");
    a_cs_freeze_state:  assert property (@(posedge clk) disable iff (srst)
        cs_n_s & ~resync |=> $stable(st_r) && $stable(step_r) && $stable(bcnt_r))
        else $error("state moved while chip select high");
    a_chan_immediate:   assert property (@(posedge clk) disable iff (srst)
        d_chsel |=> chan_r == $past(d_byte[7:4])) else $error("channel enables not immediate");
    a_active_hold:      assert property (@(posedge clk) disable iff (srst)
        ~upd_rise |=> $stable(act_r[FCFG1_OFFSET]) && $stable(chsel_act_r)) else $error("active copy changed");
    a_read_release:     assert property (@(posedge clk) disable iff (srst)
        rd_end |=> sdio_oe_r == 4'h0 ##1 sdio_oe_r == 4'h0) else $error("read pins not released");
    a_write_end_instr:  assert property (@(posedge clk) disable iff (srst)
        wr_end & ~resync |=> st_r == ST_INSTR && bcnt_r == 2'(nbytes)) else $error("cycle not ended");
    a_reset_chan_all:   assert property (@(posedge clk)
        srst |=> chan_r == 4'hf) else $error("channel enables not all set after reset");
endmodule
`default_nettype wire

// [pkg/dsc_pkg.sv]
`default_nettype none
// ============================================================
// Serial configuration port constants
package dsc_pkg;
    localparam int          NUM_CH        = 4;
    localparam int          NUM_REGS      = 25;
    localparam int          WORD_W        = 32;

    // ============================================================
    // Register map
    localparam logic [4:0]  CHSEL_OFFSET  = 5'h00;
    localparam logic [4:0]  FCFG1_OFFSET  = 5'h01;
    localparam logic [4:0]  SHARED_LO     = 5'h03;
    localparam logic [4:0]  SHARED_HI     = 5'h18;
    localparam logic [2:0]  CHSEL_BYTES   = 3'h1;
    localparam logic [2:0]  FCFG1_BYTES   = 3'h3;
    localparam logic [2:0]  DEF_BYTES     = 3'h4;

    // ============================================================
    // Channel select register fields
    localparam logic [7:0]  CHSEL_RESET     = 8'hf0;
    localparam int          CHSEL_CHAN_LSB  = 4;
    localparam int          CHSEL_MODE_LSB  = 1;
    localparam int          CHSEL_ORDER_BIT = 0;

    // ============================================================
    // Instruction byte fields
    localparam int          INS_RW_BIT    = 7;
    localparam int          INS_ADDR_MSB  = 4;

    // ============================================================
    // Serial modes
    localparam logic [1:0]  MODE_SINGLE2  = 2'h0;
    localparam logic [1:0]  MODE_SINGLE3  = 2'h1;
    localparam logic [1:0]  MODE_DUAL     = 2'h2;
    localparam logic [1:0]  MODE_QUAD     = 2'h3;

    // ============================================================
    // Link rate figures
    localparam int          SCLK_MAX_MHZ  = 200;
    localparam int          PEAK_MBPS     = SCLK_MAX_MHZ * 4;

    typedef enum logic [2:0] {
        ST_INSTR = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b100
    } dsc_state_e;
endpackage
`default_nettype wire

// [core/dsc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two flip-flop input synchroniser
module dsc_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           srst,
    // Data
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= RST;
            q      <= RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [core/dsc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Flip-flop FIFO with valid/ready on both sides
module dsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;

    wire              full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire              empty = (wp_r == rp_r);
    wire              push  = in_valid & ~full;
    wire              pop   = ~empty & out_ready;

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [sim/dsc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Serial master model, single-bit framing
module dsc_host_model (
    // Clock
    input  wire logic       clk,
    // Serial link
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      hv,
    output logic [3:0]      hoe,
    input  wire logic [3:0] pin,
    // Secondary pin levels
    input  wire logic [2:0] side
);
    logic        d0;
    logic        oe0;
    logic [31:0] rd;
    logic        keep_cs;
    assign hv  = {side, d0};
    assign hoe = {3'h7, oe0};
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        d0 = 1'b0;
        oe0 = 1'b1;
        rd = '0;
        keep_cs = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Half period of 4 cycles gives a 320 ns serial clock
    task automatic xfer(input logic [39:0] v, input int n, input int rd_from, input int pause_at);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i == pause_at) begin
                cs_n = 1'b1;
                d0 = ~d0;
                wait_clk(4);
                repeat (2) begin
                    sclk = 1'b0;
                    wait_clk(4);
                    sclk = 1'b1;
                    wait_clk(4);
                end
                cs_n = 1'b0;
            end
            sclk = 1'b0;
            oe0 = (i < rd_from);
            d0 = v[n-1-i];
            wait_clk(4);
            sclk = 1'b1;
            wait_clk(3);
            rd = {rd[30:0], pin[0]};
            wait_clk(1);
        end
        sclk = 1'b0;
        wait_clk(4);
        cs_n = ~keep_cs;
        oe0 = 1'b1;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, srst, io_update, sclk, cs_n, tg;
    logic [1:0]  act_ch, ramp, ser_mode;
    logic [4:0]  act_addr;
    logic [2:0]  side;
    logic [3:0]  hv, hoe, pin, sdio_out, sdio_oe, chan_enable;
    logic [31:0] act_data;
    logic [39:0] lv;
    int          n_mismatch, checks;
    // ============================================================
    // Pin resolution, undriven lines toggle
    assign pin = (sdio_oe & sdio_out) | (~sdio_oe & hoe & hv) | (~sdio_oe & ~hoe & {4{tg}});
    always #20 clk = ~clk;
    always @(posedge clk) tg <= ~tg;
    dsc_port_ctrl u_dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_in(pin),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .io_update(io_update), .amplitude_ramp_control(ramp),
        .act_ch(act_ch), .act_addr(act_addr), .act_data(act_data), .chan_enable(chan_enable),
        .ser_mode(ser_mode));
    dsc_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .hv(hv), .hoe(hoe), .pin(pin), .side(side));
    // ============================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic look(input logic [1:0] ch, input logic [4:0] a, input logic [31:0] exp);
        act_ch = ch;
        act_addr = a;
        tick(3);
        chk(act_data, exp);
    endtask
    task automatic upd();
        io_update = 1'b1;
        tick(4);
        io_update = 1'b0;
        tick(8);
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ============================================================
    // Tests
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        io_update = 1'b0;
        tg = 1'b0;
        act_ch = 2'h0;
        act_addr = 5'h00;
        side = 3'h0;
        n_mismatch = 0;
        checks = 0;
        tick(10);
        srst = 1'b0;
        tick(4);
        chk(32'(chan_enable), 32'hf);
        chk(32'(ser_mode), 32'h0);
        chk(32'(sdio_oe), 32'h0);
        side = 3'h2;
        tick(4);
        chk(32'(ramp), 32'h2);
        side = 3'h0;
        done("reset");
        u_host.xfer(40'h01abcdef, 32, 99, 99);
        upd();
        look(2'h0, 5'h01, 32'h00abcdef);
        u_host.xfer(40'h0411223344, 40, 99, 20);
        upd();
        look(2'h0, 5'h04, 32'h11223344);
        look(2'h3, 5'h04, 32'h11223344);
        done("write");
        u_host.xfer(40'h0020, 16, 99, 99);
        tick(8);
        chk(32'(chan_enable), 32'h2);
        u_host.xfer(40'h0455667788, 40, 99, 99);
        tick(8);
        look(2'h1, 5'h04, 32'h11223344);
        upd();
        look(2'h1, 5'h04, 32'h55667788);
        look(2'h0, 5'h04, 32'h11223344);
        done("channel");
        u_host.xfer(40'h04a53, 20, 99, 99);
        side = 3'h4;
        tick(8);
        side = 3'h0;
        tick(8);
        upd();
        look(2'h1, 5'h04, 32'ha5667788);
        done("abort");
        u_host.xfer(40'he400000000, 40, 8, 99);
        chk(u_host.rd, 32'ha5667788);
        tick(4);
        chk(32'(sdio_oe), 32'h0);
        done("read");
        u_host.keep_cs = 1'b1;
        u_host.xfer(40'h01123456, 32, 99, 99);
        u_host.xfer(40'h01654321, 32, 99, 99);
        u_host.keep_cs = 1'b0;
        upd();
        look(2'h0, 5'h01, 32'h00654321);
        done("framing");
        u_host.xfer(40'h0021, 16, 99, 99);
        upd();
        chk(32'(ser_mode), 32'h0);
        lv = {<<{40'h1122334404}};
        u_host.xfer(lv, 40, 99, 99);
        upd();
        look(2'h1, 5'h04, 32'h11223344);
        done("order");
        close_out();
    end
    initial begin
        #1000000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
